//--- design/parallel_io_and_interval_timer.sv
// Parallel I/O ports and 14-bit interval timer with an APB register slave
// Functional notes
// - 22 lines, each port's direction chosen by software configuration
// - Ports 1,2 plain/strobed in/out; ports 3,4 plain in or latched out
// - Port 1 strobed modes turn port 3 into its handshake lines
// - Port 2 strobed modes turn port 4 into its handshake lines
// - 14-bit down timer, software picks one of four waveform functions
// - Current count readable any time without disturbing the count
// - Single pulse: output low only during second half of count
// - Square wave: high first half, low rest, length reloads at terminal
// - Rate generator: low pulse and new timeout at every terminal count
// - Strobe: exactly one low pulse at terminal count, no repeat
// - Timer counts cycles of a 122.88 kHz reference clock input
`timescale 1ns/100ps

module parallel_io_and_interval_timer (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Parallel ports
	input  wire logic [7:0]  port1_in,
	output logic      [7:0]  port1_out,
	output logic      [7:0]  port1_oe_out,
	input  wire logic [7:0]  port2_in,
	output logic      [7:0]  port2_out,
	output logic      [7:0]  port2_oe_out,
	input  wire logic [2:0]  port3_in,
	output logic      [2:0]  port3_out,
	output logic      [2:0]  port3_oe_out,
	input  wire logic [2:0]  port4_in,
	output logic      [2:0]  port4_out,
	output logic      [2:0]  port4_oe_out,
	// Timer
	input  wire logic        timer_ref_in,
	output logic             timer_out
);

	// ==========================================
	// Input synchronisers
	logic [15:0] big_s1_r;
	logic [15:0] big_s2_r;
	logic [5:0]  small_s1_r;
	logic [5:0]  small_s2_r;
	logic        ref_s1_r;
	logic        ref_s2_r;
	logic        ref_s3_r;
	logic        tick;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			big_s1_r   <= '0;
			big_s2_r   <= '0;
			small_s1_r <= '0;
			small_s2_r <= '0;
			ref_s1_r   <= 1'b0;
			ref_s2_r   <= 1'b0;
			ref_s3_r   <= 1'b0;
		end else begin
			big_s1_r   <= {port2_in, port1_in};
			big_s2_r   <= big_s1_r;
			small_s1_r <= {port4_in, port3_in};
			small_s2_r <= small_s1_r;
			ref_s1_r   <= timer_ref_in;
			ref_s2_r   <= ref_s1_r;
			ref_s3_r   <= ref_s2_r;
		end
	end

	assign tick = ref_s2_r & ~ref_s3_r;

	// ==========================================
	// APB decode
	logic [2:0]  idx;
	logic        addr_ok;
	logic        setup;
	logic        acc_wr;
	logic        acc_rd;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;

	assign idx     = paddr_in[pio_timer_pkg::IDX_MSB:pio_timer_pkg::IDX_LSB];
	assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[7:5] == 3'h0)
		&& (idx <= pio_timer_pkg::IDX_THI);
	assign setup   = psel_in & ~penable_in;
	assign acc_wr  = psel_in & penable_in & pready_r & pwrite_in & addr_ok;
	assign acc_rd  = psel_in & penable_in & pready_r & ~pwrite_in & addr_ok;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~addr_ok;
			prdata_r  <= (setup & ~pwrite_in & addr_ok) ? rd_mux : '0;
		end
	end

	assign pready_out  = pready_r;
	assign pslverr_out = pslverr_r;
	assign prdata_out  = prdata_r;

	// ==========================================
	// Configuration and small port latches
	logic [5:0] cfg_r;
	logic [5:0] small_latch_r;
	logic       wr_cmd;

	assign wr_cmd = acc_wr && (idx == pio_timer_pkg::IDX_CMD);

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_r         <= '0;
			small_latch_r <= '0;
		end else begin
			if (wr_cmd)
				cfg_r <= pwdata_in[pio_timer_pkg::CFG_W-1:0];
			if (acc_wr && (idx == pio_timer_pkg::IDX_PORT34))
				small_latch_r <= pwdata_in[5:0];
		end
	end

	// ==========================================
	// Large ports with strobed handshake
	wire [1:0]  bf_w;
	wire [15:0] big_q_w;
	wire [15:0] big_rd_w;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_big
			logic [7:0] out_latch_r;
			logic [7:0] in_latch_r;
			logic       bf_r;
			logic       stb_d_r;
			logic       dir_out;
			logic       strobed;
			logic       rise;
			logic       wr_hit;
			logic       rd_hit;
			logic       bf_set;
			logic       bf_clr;

			assign dir_out = cfg_r[pio_timer_pkg::CFG_P1_OUT + g];
			assign strobed = cfg_r[pio_timer_pkg::CFG_P1_STB + g];
			assign rise    = small_s2_r[3*g + pio_timer_pkg::HS_STB] & ~stb_d_r;
			assign wr_hit  = acc_wr && (idx == pio_timer_pkg::IDX_PORT1 + 3'(g));
			assign rd_hit  = acc_rd && (idx == pio_timer_pkg::IDX_PORT1 + 3'(g));
			assign bf_set  = strobed & (dir_out ? wr_hit : rise);
			assign bf_clr  = strobed & (dir_out ? rise : rd_hit);

			always_ff @(posedge core_clk_in or posedge reset_in) begin
				if (reset_in) begin
					out_latch_r <= '0;
					in_latch_r  <= '0;
					bf_r        <= 1'b0;
					stb_d_r     <= 1'b1;
				end else begin
					stb_d_r <= small_s2_r[3*g + pio_timer_pkg::HS_STB];
					if (wr_hit)
						out_latch_r <= pwdata_in[7:0];
					if (strobed && !dir_out && rise)
						in_latch_r <= big_s2_r[8*g +: 8];
					bf_r <= bf_set | (bf_r & ~bf_clr);
				end
			end

			assign bf_w[g]         = bf_r;
			assign big_q_w[8*g +: 8]  = out_latch_r;
			assign big_rd_w[8*g +: 8] = dir_out ? out_latch_r
				: (strobed ? in_latch_r : big_s2_r[8*g +: 8]);
		end
	endgenerate

	// ==========================================
	// Pin drivers
	logic [2:0] p3_out_nxt;
	logic [2:0] p3_oe_nxt;
	logic [2:0] p4_out_nxt;
	logic [2:0] p4_oe_nxt;

	always_comb begin
		p3_out_nxt = small_latch_r[2:0];
		p3_oe_nxt  = {3{cfg_r[pio_timer_pkg::CFG_P3_OUT]}};
		p4_out_nxt = small_latch_r[5:3];
		p4_oe_nxt  = {3{cfg_r[pio_timer_pkg::CFG_P4_OUT]}};
		if (cfg_r[pio_timer_pkg::CFG_P1_STB]) begin
			p3_out_nxt = {3{bf_w[0]}} & pio_timer_pkg::HS_OE;
			p3_oe_nxt  = pio_timer_pkg::HS_OE;
		end
		if (cfg_r[pio_timer_pkg::CFG_P2_STB]) begin
			p4_out_nxt = {3{bf_w[1]}} & pio_timer_pkg::HS_OE;
			p4_oe_nxt  = pio_timer_pkg::HS_OE;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			port1_out    <= '0;
			port1_oe_out <= '0;
			port2_out    <= '0;
			port2_oe_out <= '0;
			port3_out    <= '0;
			port3_oe_out <= '0;
			port4_out    <= '0;
			port4_oe_out <= '0;
		end else begin
			port1_out    <= big_q_w[7:0];
			port1_oe_out <= {8{cfg_r[pio_timer_pkg::CFG_P1_OUT]}};
			port2_out    <= big_q_w[15:8];
			port2_oe_out <= {8{cfg_r[pio_timer_pkg::CFG_P2_OUT]}};
			port3_out    <= p3_out_nxt;
			port3_oe_out <= p3_oe_nxt;
			port4_out    <= p4_out_nxt;
			port4_oe_out <= p4_oe_nxt;
		end
	end

	// ==========================================
	// Interval timer
	logic [13:0] cnt_r;
	logic [13:0] len_r;
	logic [13:0] half;
	logic [1:0]  mode_r;
	logic        running_r;
	logic        stop_tc_r;
	logic        tc_flag_r;
	logic        tmr_out_r;
	logic        tc_ev;
	logic        one_shot;
	logic [1:0]  tcmd;

	assign half     = len_r >> 1;
	assign tcmd     = pwdata_in[pio_timer_pkg::CMD_TMR_LSB +: 2];
	assign tc_ev    = running_r & tick & (cnt_r <= pio_timer_pkg::CNT_TC);
	assign one_shot = (mode_r == pio_timer_pkg::TM_PULSE)
		|| (mode_r == pio_timer_pkg::TM_STROBE) || stop_tc_r;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			len_r  <= pio_timer_pkg::LEN_RST;
			mode_r <= pio_timer_pkg::TM_PULSE;
		end else begin
			if (acc_wr && (idx == pio_timer_pkg::IDX_TLO))
				len_r[7:0] <= pwdata_in[7:0];
			if (acc_wr && (idx == pio_timer_pkg::IDX_THI)) begin
				len_r[13:8] <= pwdata_in[5:0];
				mode_r      <= pwdata_in[pio_timer_pkg::THI_MODE_LSB +: 2];
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_r     <= '0;
			running_r <= 1'b0;
			stop_tc_r <= 1'b0;
		end else if (wr_cmd && ((tcmd == pio_timer_pkg::TC_START)
			|| (tcmd == pio_timer_pkg::TC_STOP))) begin
			case (tcmd)
				pio_timer_pkg::TC_START: begin
					running_r <= 1'b1;
					cnt_r     <= len_r;
					stop_tc_r <= 1'b0;
				end
				default: begin
					running_r <= 1'b0;
				end
			endcase
		end else begin
			// Other command writes must not swallow a count step
			if (wr_cmd && (tcmd == pio_timer_pkg::TC_STOP_AT_TC))
				stop_tc_r <= running_r;
			if (tc_ev) begin
				cnt_r <= len_r;
				if (one_shot) begin
					running_r <= 1'b0;
					stop_tc_r <= 1'b0;
				end
			end else if (running_r && tick) begin
				cnt_r <= cnt_r - 14'h0001;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tc_flag_r <= 1'b0;
			tmr_out_r <= 1'b1;
		end else begin
			tc_flag_r <= tc_ev | (tc_flag_r
				& ~(acc_rd && (idx == pio_timer_pkg::IDX_CMD)));
			if (!running_r)
				tmr_out_r <= 1'b1;
			else if ((mode_r == pio_timer_pkg::TM_PULSE)
				|| (mode_r == pio_timer_pkg::TM_SQUARE))
				tmr_out_r <= (cnt_r > half);
			else
				tmr_out_r <= (cnt_r > pio_timer_pkg::CNT_TC);
		end
	end

	assign timer_out = tmr_out_r;

	// ==========================================
	// Read mux
	always_comb begin
		rd_mux = '0;
		case (idx)
			pio_timer_pkg::IDX_CMD: begin
				rd_mux[pio_timer_pkg::ST_P1_BF] = bf_w[0];
				rd_mux[pio_timer_pkg::ST_P2_BF] = bf_w[1];
				rd_mux[pio_timer_pkg::ST_TC]    = tc_flag_r;
				rd_mux[pio_timer_pkg::ST_RUN]   = running_r;
			end
			pio_timer_pkg::IDX_PORT1:  rd_mux[7:0] = big_rd_w[7:0];
			pio_timer_pkg::IDX_PORT2:  rd_mux[7:0] = big_rd_w[15:8];
			pio_timer_pkg::IDX_PORT34: begin
				rd_mux[2:0] = cfg_r[pio_timer_pkg::CFG_P3_OUT]
					? small_latch_r[2:0] : small_s2_r[2:0];
				rd_mux[5:3] = cfg_r[pio_timer_pkg::CFG_P4_OUT]
					? small_latch_r[5:3] : small_s2_r[5:3];
			end
			pio_timer_pkg::IDX_TLO: rd_mux[7:0] = cnt_r[7:0];
			pio_timer_pkg::IDX_THI: rd_mux[7:0] = {mode_r, cnt_r[13:8]};
			default: rd_mux = '0;
		endcase
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_tc_plain;
		tc_ev && !wr_cmd;
	endsequence

	sequence s_rd_tlo;
		setup && !pwrite_in && addr_ok && (idx == pio_timer_pkg::IDX_TLO);
	endsequence

	property p_dir1;
		!cfg_r[pio_timer_pkg::CFG_P1_OUT] |=> (port1_oe_out == 8'h00);
	endproperty
	a_dir1: assert property (p_dir1) else $error("port1 driven while input");

	property p_small;
		!cfg_r[pio_timer_pkg::CFG_P1_STB] && cfg_r[pio_timer_pkg::CFG_P3_OUT]
			|=> (port3_oe_out == 3'h7) && (port3_out == $past(small_latch_r[2:0]));
	endproperty
	a_small: assert property (p_small) else $error("port3 output wrong");

	property p_hs3;
		cfg_r[pio_timer_pkg::CFG_P1_STB]
			|=> (port3_oe_out == 3'h1) && (port3_out[0] == $past(bf_w[0]));
	endproperty
	a_hs3: assert property (p_hs3) else $error("port3 not handshake");

	property p_hs4;
		cfg_r[pio_timer_pkg::CFG_P2_STB]
			|=> (port4_oe_out == 3'h1) && (port4_out[0] == $past(bf_w[1]));
	endproperty
	a_hs4: assert property (p_hs4) else $error("port4 not handshake");

	property p_start;
		wr_cmd && (tcmd == pio_timer_pkg::TC_START)
			|=> running_r && (cnt_r == $past(len_r));
	endproperty
	a_start: assert property (p_start) else $error("timer start failed");

	property p_live;
		s_rd_tlo ##0 (running_r && !tc_ev)
			|=> (prdata_out[7:0] == $past(cnt_r[7:0])) && running_r;
	endproperty
	a_live: assert property (p_live) else $error("count read wrong");

	property p_pulse;
		running_r && (mode_r == pio_timer_pkg::TM_PULSE) && (cnt_r <= half)
			|=> !timer_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse not low");

	property p_square;
		s_tc_plain ##0 (mode_r == pio_timer_pkg::TM_SQUARE) && !stop_tc_r
			|=> running_r && (cnt_r == $past(len_r));
	endproperty
	a_square: assert property (p_square) else $error("square no reload");

	property p_rate;
		running_r && (mode_r == pio_timer_pkg::TM_RATE) && (cnt_r == pio_timer_pkg::CNT_TC)
			|=> !timer_out;
	endproperty
	a_rate: assert property (p_rate) else $error("rate pulse missing");

	property p_strobe;
		s_tc_plain ##0 (mode_r == pio_timer_pkg::TM_STROBE) |=> !running_r ##1 timer_out;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe repeated");

	property p_tick;
		tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("double reference tick");

	property p_dec;
		running_r && tick && (cnt_r > pio_timer_pkg::CNT_TC) && !wr_cmd
			|=> (cnt_r == $past(cnt_r) - 14'h0001);
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");

endmodule

//--- design/pio_timer_pkg.sv
// Constants, register map and encodings of the parallel port and timer block
package pio_timer_pkg;

	// ==========================================
	// Bus and register map
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          IDX_LSB      = 2;
	localparam int          IDX_MSB      = 4;
	localparam logic [2:0]  IDX_CMD      = 3'h0;
	localparam logic [2:0]  IDX_PORT1    = 3'h1;
	localparam logic [2:0]  IDX_PORT2    = 3'h2;
	localparam logic [2:0]  IDX_PORT34   = 3'h3;
	localparam logic [2:0]  IDX_TLO      = 3'h4;
	localparam logic [2:0]  IDX_THI      = 3'h5;

	// ==========================================
	// Configuration bits of the command register
	localparam int          CFG_W        = 6;
	localparam int          CFG_P1_OUT   = 0;
	localparam int          CFG_P2_OUT   = 1;
	localparam int          CFG_P1_STB   = 2;
	localparam int          CFG_P2_STB   = 3;
	localparam int          CFG_P3_OUT   = 4;
	localparam int          CFG_P4_OUT   = 5;
	localparam int          CMD_TMR_LSB  = 6;

	typedef enum logic [1:0] {
		TC_NOP        = 2'b00,
		TC_STOP       = 2'b01,
		TC_STOP_AT_TC = 2'b10,
		TC_START      = 2'b11
	} timer_cmd_e;

	// ==========================================
	// Status bits
	localparam int          ST_P1_BF     = 0;
	localparam int          ST_P2_BF     = 1;
	localparam int          ST_TC        = 2;
	localparam int          ST_RUN       = 3;

	// ==========================================
	// Ports and handshake lines
	localparam int          BIG_W        = 8;
	localparam int          SMALL_W      = 3;
	localparam int          P4_LSB       = 3;
	localparam int          HS_BF        = 0;
	localparam int          HS_STB       = 1;
	localparam logic [2:0]  HS_OE        = 3'h1;

	// ==========================================
	// Timer
	localparam int          CNT_W        = 14;
	localparam int          THI_MODE_LSB = 6;
	localparam logic [13:0] CNT_TC       = 14'h0001;
	localparam logic [13:0] LEN_RST      = 14'h0002;

	typedef enum logic [1:0] {
		TM_PULSE  = 2'b00,
		TM_SQUARE = 2'b01,
		TM_RATE   = 2'b10,
		TM_STROBE = 2'b11
	} timer_mode_e;

endpackage

//--- sim/periph_model.sv
// Peripheral model standing on the parallel lines of the port block
`timescale 1ns/100ps

module periph_model (
	// Clock
	input  wire logic       clk_in,
	// Block side of each port
	input  wire logic [7:0] p1_q_in,
	input  wire logic [7:0] p1_oe_in,
	input  wire logic [7:0] p2_q_in,
	input  wire logic [7:0] p2_oe_in,
	input  wire logic [2:0] p3_q_in,
	input  wire logic [2:0] p3_oe_in,
	input  wire logic [2:0] p4_q_in,
	input  wire logic [2:0] p4_oe_in,
	// Resolved line levels
	output logic      [7:0] p1_pin_out,
	output logic      [7:0] p2_pin_out,
	output logic      [2:0] p3_pin_out,
	output logic      [2:0] p4_pin_out
);
	logic [7:0] d1_r = 8'h00;
	logic [7:0] d2_r = 8'h00;
	logic [2:0] d3_r = 3'h2;
	logic [2:0] d4_r = 3'h2;

	// ==========================================
	// Line resolution: block drives where enabled
	assign p1_pin_out = (p1_oe_in & p1_q_in) | (~p1_oe_in & d1_r);
	assign p2_pin_out = (p2_oe_in & p2_q_in) | (~p2_oe_in & d2_r);
	assign p3_pin_out = (p3_oe_in & p3_q_in) | (~p3_oe_in & d3_r);
	assign p4_pin_out = (p4_oe_in & p4_q_in) | (~p4_oe_in & d4_r);

	// ==========================================
	// Line driving
	task automatic drive(input logic [7:0] a, input logic [7:0] b,
		input logic [2:0] c, input logic [2:0] d);
		@(posedge clk_in);
		d1_r <= a;
		d2_r <= b;
		d3_r <= c;
		d4_r <= d;
	endtask

	// Strobe held low four clocks, data settled well before the rise
	task automatic strobe(input logic sel);
		@(posedge clk_in);
		if (sel) d4_r[1] <= 1'b0;
		else d3_r[1] <= 1'b0;
		repeat (4) @(posedge clk_in);
		if (sel) d4_r[1] <= 1'b1;
		else d3_r[1] <= 1'b1;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the parallel port and interval timer block
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[FAIL] %s expected %h seen %h", n, e, g); \
	end \
end

module tb;
	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic        ref_clk  = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_out;
	logic [7:0]  p1_q, p1_oe, p1_pin, p2_q, p2_oe, p2_pin;
	logic [2:0]  p3_q, p3_oe, p3_pin, p4_q, p4_oe, p4_pin;
	logic [31:0] rd;
	logic        er;
	logic [13:0] cnt;
	logic        run;
	logic        exp_out;
	int          fails       = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	// Reference runs faster than nominal to keep the run short
	always #5 core_clk = ~core_clk;
	always #100 ref_clk = ~ref_clk;

	parallel_io_and_interval_timer u_dut (
		.core_clk_in(core_clk), .reset_in(reset), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.port1_in(p1_pin), .port1_out(p1_q), .port1_oe_out(p1_oe),
		.port2_in(p2_pin), .port2_out(p2_q), .port2_oe_out(p2_oe),
		.port3_in(p3_pin), .port3_out(p3_q), .port3_oe_out(p3_oe),
		.port4_in(p4_pin), .port4_out(p4_q), .port4_oe_out(p4_oe),
		.timer_ref_in(ref_clk), .timer_out(timer_out));

	periph_model u_per (
		.clk_in(core_clk), .p1_q_in(p1_q), .p1_oe_in(p1_oe), .p2_q_in(p2_q),
		.p2_oe_in(p2_oe), .p3_q_in(p3_q), .p3_oe_in(p3_oe), .p4_q_in(p4_q),
		.p4_oe_in(p4_oe), .p1_pin_out(p1_pin), .p2_pin_out(p2_pin),
		.p3_pin_out(p3_pin), .p4_pin_out(p4_pin));

	// ==========================================
	// Bus access and closing
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	// ==========================================
	// Test sequence
	initial begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		#1;
		`CHK("timer idle", 1'b1, timer_out) // stopped high
		apb(1'b0, 8'h18, 32'h0);
		`CHK("unmapped", 33'h100000000, {er, rd}) // map bounds
		apb(1'b0, 8'h05, 32'h0);
		`CHK("misaligned", 1'b1, er) // map bounds
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, 8'h00, {26'h0, i[3], i[2], 2'b00, i[1], i[0]});
			@(posedge core_clk);
			#1;
			`CHK("dir", {{8{i[0]}}, {8{i[1]}}, {3{i[2]}}, {3{i[3]}}}, {p1_oe, p2_oe, p3_oe, p4_oe})
		end
		apb(1'b1, 8'h04, 32'ha5);
		apb(1'b1, 8'h08, 32'h5a);
		apb(1'b1, 8'h0c, 32'h2d);
		@(posedge core_clk);
		#1;
		`CHK("latched out", {8'ha5, 8'h5a, 3'h5, 3'h5}, {p1_q, p2_q, p3_q, p4_q})
		apb(1'b0, 8'h04, 32'h0);
		`CHK("p1 readback", 32'ha5, rd)
		apb(1'b1, 8'h00, 32'h0);
		u_per.drive(8'h3c, 8'hc3, 3'h6, 3'h3);
		repeat (4) @(posedge core_clk);
		apb(1'b0, 8'h04, 32'h0);
		`CHK("p1 in", 32'h3c, rd)
		apb(1'b0, 8'h08, 32'h0);
		`CHK("p2 in", 32'hc3, rd)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK("p34 in", 32'h1e, rd)
		apb(1'b1, 8'h00, 32'h04);
		u_per.drive(8'h77, 8'h00, 3'h2, 3'h2);
		#1;
		`CHK("p3 control", pio_timer_pkg::HS_OE, p3_oe)
		u_per.strobe(1'b0);
		u_per.drive(8'h11, 8'h00, 3'h2, 3'h2);
		`CHK("p3 full", 1'b1, p3_q[0])
		apb(1'b0, 8'h00, 32'h0);
		`CHK("full 1 set", 32'h1, rd & 32'h1)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("p1 strobed", 32'h77, rd)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("full 1 clear", 32'h0, rd & 32'h1)
		apb(1'b1, 8'h00, 32'h0a);
		apb(1'b1, 8'h08, 32'h99);
		@(posedge core_clk);
		#1;
		`CHK("p4 control", {8'h99, 8'hff, 3'h1, 1'b1}, {p2_q, p2_oe, p4_oe, p4_q[0]})
		u_per.strobe(1'b1);
		`CHK("p4 full clear", 1'b0, p4_q[0])
		apb(1'b0, 8'h00, 32'h0);
		`CHK("full 2 clear", 32'h0, rd & 32'h2)
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 8'h10, 32'h06);
			apb(1'b1, 8'h14, 32'(m << 6));
			apb(1'b0, 8'h14, 32'h0);
			`CHK("mode", m[1:0], rd[7:6])
			@(posedge ref_clk);
			repeat (5) @(posedge core_clk);
			apb(1'b1, 8'h00, 32'hc0);
			for (int k = 1; k < 15; k++) begin
				@(posedge ref_clk);
				repeat (12) @(posedge core_clk);
				cnt = 14'(6 - k % 6);
				run = (m == 1 || m == 2 || k < 6);
				exp_out = !run || ((m < 2) ? (cnt > 14'd3) : (cnt != 14'd1));
				`CHK("timer out", exp_out, timer_out)
				if (run) begin
					apb(1'b0, 8'h10, 32'h0);
					`CHK("count", cnt[7:0], rd[7:0])
				end
			end
		end
		apb(1'b0, 8'h00, 32'h0);
		`CHK("tc flag", 2'b01, rd[3:2])
		apb(1'b0, 8'h00, 32'h0);
		`CHK("tc flag clear", 1'b0, rd[2])
		apb(1'b1, 8'h10, 32'hff);
		apb(1'b1, 8'h14, 32'h7f);
		@(posedge ref_clk);
		repeat (5) @(posedge core_clk);
		apb(1'b1, 8'h00, 32'hc0);
		apb(1'b0, 8'h14, 32'h0);
		`CHK("count high", 32'h7f, rd)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("count low", 32'hff, rd)
		apb(1'b1, 8'h00, 32'h40);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("stopped", 1'b1, timer_out) // stop command
		apb(1'b0, 8'h00, 32'h0);
		`CHK("stop run bit", 1'b0, rd[3]) // stop command
		apb(1'b1, 8'h10, 32'h03);
		apb(1'b1, 8'h14, 32'h40);
		apb(1'b1, 8'h00, 32'hc0);
		apb(1'b1, 8'h00, 32'h80);
		repeat (2) @(posedge ref_clk);
		apb(1'b0, 8'h00, 32'h0);
		`CHK("stop at tc pending", 1'b1, rd[3]) // stop at terminal
		repeat (3) @(posedge ref_clk);
		repeat (5) @(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		`CHK("stop at tc", 2'b01, rd[3:2]) // stop at terminal
		wrap_up();
	end
endmodule
